// File: design/rtci_defs.vh
/*
 * Constants of the clock-chip serial target: bus address, pointer byte
 * layout, reset values and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef RTCI_DEFS_VH
`define RTCI_DEFS_VH

// Seven-bit target address on the two-wire bus
`define RTCI_TARGET_ADDR 7'h32
// Pointer byte: pointer in the high nibble, format in the low nibble
`define RTCI_PTR_MSB 7
`define RTCI_PTR_LSB 4
`define RTCI_FMT_MSB 3
`define RTCI_FMT_LSB 0
// Pointer value after reset, stop or timeout
`define RTCI_PTR_DEFAULT 4'hf
// Format codes
`define RTCI_FMT_NORMAL 4'h0
`define RTCI_FMT_SHORT 4'h4
// Byte returned once the transaction was cut off
`define RTCI_DEAD_BYTE 8'hff
// Timebase rate and the bus-release timeout (0.5 s of 32.768 kHz ticks)
`define RTCI_TICK_HZ 32768
`define RTCI_TO_MS 500
`define RTCI_TO_TICKS 15'd16384
`define RTCI_TO_W 15
// Latest time after a stop to apply a held carry, and the clock period
`define RTCI_CARRY_MAX_NS 61000
`define RTCI_CLK_NS 8
`define RTCI_CARRY_MAX_CYC (`RTCI_CARRY_MAX_NS / `RTCI_CLK_NS)

`endif

// File: design/rtci_fifo.v
/*
 * Small synchronous FIFO of flip-flops with valid/ready on both sides.
 * Assumes one clock, active-low asynchronous reset, and a clock enable
 * that freezes all state while low.
 */
`timescale 1ns/1ns
`default_nettype none

module rtci_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire sys_clk,
   input wire resetn,
   input wire ce,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // Storage words
   reg [AW-1:0] wp_r; // Write index
   reg [AW-1:0] rp_r; // Read index
   reg [AW:0] cnt_r; // Words held
   wire push;
   wire pop;

   // Full and empty come straight from the count
   assign in_ready = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem_r[rp_r];
   assign push = in_valid & in_ready & ce;
   assign pop = out_valid & out_ready & ce;

   // Storage write, no reset needed for data
   always @(posedge sys_clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   // Index and count upkeep, wrap at the depth
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         if (push & !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // rtci_fifo

`default_nettype wire

// File: design/rtci_target.v
/*
 * Two-wire serial target of a real-time clock: address match, pointer
 * and format byte, three read forms, write data into a FIFO, time hold
 * with carry deferral, and the bus-release timeout.
 * Assumes the register file answers reg_rd_data for reg_rd_addr in the
 * same cycle, tick_32k is a one-cycle pulse at 32.768 kHz, carry_in is a
 * one-cycle pulse from the timekeeping prescaler, and SCL/SDA come from
 * pins outside the clock domain.
 */
// How it works
// - Pointer write, repeated start, read from pointer
// - Every stop forces pointer to F
// - Format four: transmit right after pointer byte
// - Short read starts at the written pointer
// - Bare read starts at pointer F
// - Pointer advances per byte, F wraps to 0
// - Hold time during transaction, carry after stop
// - Timeout aborts like stop: release, unhold, F
// - Repeated start never restarts the timeout
// - After abort: write NACKed, reads give FF
// - Answer only target address 0110010
// - Pointer byte: pointer nibble plus format nibble
`timescale 1ns/1ns
`default_nettype none
`include "rtci_defs.vh"

module rtci_target #(
   parameter [`RTCI_TO_W-1:0] TO_TICKS = `RTCI_TO_TICKS,
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW = 5
) (
   input wire sys_clk,
   input wire resetn,
   input wire ce,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe,
   input wire tick_32k,
   input wire carry_in,
   output wire carry_out,
   output wire time_hold,
   output wire [3:0] reg_rd_addr,
   input wire [7:0] reg_rd_data,
   output wire reg_wr_valid,
   input wire reg_wr_ready,
   output wire [3:0] reg_wr_addr,
   output wire [7:0] reg_wr_data
);
   // One-hot states
   localparam [8:0] ST_IDLE = 9'h001; // Not addressed, wait for start or stop
   localparam [8:0] ST_ADDR = 9'h002; // Shift in address byte
   localparam [8:0] ST_AACK = 9'h004; // Address acknowledge slot
   localparam [8:0] ST_PTR = 9'h008; // Shift in pointer byte
   localparam [8:0] ST_PACK = 9'h010; // Pointer acknowledge slot
   localparam [8:0] ST_WDAT = 9'h020; // Shift in write data
   localparam [8:0] ST_WACK = 9'h040; // Write data acknowledge slot
   localparam [8:0] ST_TX = 9'h080; // Shift out read data
   localparam [8:0] ST_MACK = 9'h100; // Host acknowledge slot

   wire [1:0] filt_w; // Agreed levels, 0 = scl, 1 = sda
   wire [1:0] prev_w; // Agreed levels one cycle back
   reg [8:0] state_r; // Protocol state
   reg [3:0] bit_r; // Bits moved in current byte
   reg [7:0] sh_r; // Shift register
   reg [3:0] ptr_r; // Register address pointer
   reg oe_r; // Pull SDA low
   reg rd_r; // Read asked by address byte or short format; host ACK in ST_MACK
   reg trans_r; // Between first start and stop
   reg dead_r; // Transaction cut off by timeout
   reg hold_r; // Time values frozen
   reg pend_r; // Carry waiting for release
   reg cout_r; // Carry pulse to timekeeping
   reg [`RTCI_TO_W-1:0] to_r; // Ticks since first start
   wire timeout;
   wire fifo_in_ready;

   // Read byte source: dead transactions read as all ones
   function [7:0] tx_byte;
      input dead;
      input [7:0] data;
      begin
         tx_byte = dead ? `RTCI_DEAD_BYTE : data;
      end
   endfunction

   // Pin synchronisers; only stage 2 and 3 are looked at
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         reg [2:0] sync_r; // Three-stage synchroniser, one per pin
         reg filt_r; // Agreed level
         reg prev_r; // Agreed level one cycle back
         always @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               {sync_r, filt_r, prev_r} <= 5'h1f;
            end else if (ce) begin
               sync_r <= {sync_r[1:0], (gi == 0) ? scl_i : sda_i};
               // Level changes only once stages two and three agree
               if (sync_r[1] == sync_r[2]) begin
                  filt_r <= sync_r[2];
               end
               prev_r <= filt_r;
            end
         end
         assign filt_w[gi] = filt_r;
         assign prev_w[gi] = prev_r;
      end
   endgenerate

   wire scl_f = filt_w[0]; // Filtered clock level
   wire sda_f = filt_w[1]; // Filtered data level
   wire scl_rise = scl_f & !prev_w[0];
   wire scl_fall = !scl_f & prev_w[0];
   // SDA moves while SCL stays high
   wire start_ev = scl_f & prev_w[0] & prev_w[1] & !sda_f;
   wire stop_ev = scl_f & prev_w[0] & !prev_w[1] & sda_f;
   // Expiry after 0.5 s of ticks
   assign timeout = trans_r & !dead_r & tick_32k & (to_r == TO_TICKS - 1'b1);

   // Open-drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = oe_r;
   assign time_hold = hold_r;
   assign carry_out = cout_r;
   assign reg_rd_addr = ptr_r;

   // Protocol engine
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         ptr_r <= `RTCI_PTR_DEFAULT;
         oe_r <= 1'b0;
         rd_r <= 1'b0;
         trans_r <= 1'b0;
         dead_r <= 1'b0;
         hold_r <= 1'b0;
         to_r <= {`RTCI_TO_W{1'b0}};
      end else if (ce) begin
         if (stop_ev) begin
            // Stop resets pointer, ends hold and timeout
            state_r <= ST_IDLE;
            oe_r <= 1'b0;
            ptr_r <= `RTCI_PTR_DEFAULT;
            trans_r <= 1'b0;
            dead_r <= 1'b0;
            hold_r <= 1'b0;
            to_r <= {`RTCI_TO_W{1'b0}};
         end else if (start_ev) begin
            state_r <= ST_ADDR;
            bit_r <= 4'h0;
            oe_r <= 1'b0;
            // Only the first start opens hold and clears count
            if (!trans_r) begin
               trans_r <= 1'b1;
               hold_r <= 1'b1;
               to_r <= {`RTCI_TO_W{1'b0}};
            end
         end else if (timeout) begin
            // Abort as a stop would, but stay marked dead
            state_r <= ST_IDLE;
            oe_r <= 1'b0;
            ptr_r <= `RTCI_PTR_DEFAULT;
            hold_r <= 1'b0;
            dead_r <= 1'b1;
         end else begin
            // Count ticks while the transaction is live
            if (trans_r && !dead_r && tick_32k) begin
               to_r <= to_r + 1'b1;
            end
            case (state_r)
               ST_ADDR, ST_PTR, ST_WDAT: begin
                  if (scl_rise) begin
                     sh_r <= {sh_r[6:0], sda_f};
                     bit_r <= bit_r + 1'b1;
                  end else if (scl_fall && bit_r == 4'h8) begin
                     bit_r <= 4'h0;
                     if (state_r == ST_ADDR) begin
                        if (sh_r[7:1] == `RTCI_TARGET_ADDR && (sh_r[0] || !dead_r)) begin
                           oe_r <= 1'b1;
                           rd_r <= sh_r[0];
                           state_r <= ST_AACK;
                        end else begin
                           state_r <= ST_IDLE;
                        end
                     end else if (state_r == ST_PTR) begin
                        ptr_r <= sh_r[`RTCI_PTR_MSB:`RTCI_PTR_LSB];
                        rd_r <= (sh_r[`RTCI_FMT_MSB:`RTCI_FMT_LSB] == `RTCI_FMT_SHORT);
                        oe_r <= 1'b1;
                        state_r <= ST_PACK;
                     end else if (fifo_in_ready) begin
                        // Byte queued at pointer, pointer steps on
                        oe_r <= 1'b1;
                        ptr_r <= ptr_r + 1'b1;
                        state_r <= ST_WACK;
                     end else begin
                        // Queue full: refuse the byte
                        state_r <= ST_IDLE;
                     end
                  end
               end
               ST_AACK, ST_PACK, ST_WACK: begin
                  if (scl_fall) begin
                     bit_r <= 4'h0;
                     if (rd_r && state_r != ST_WACK) begin
                        sh_r <= tx_byte(dead_r, reg_rd_data);
                        oe_r <= !tx_byte(dead_r, reg_rd_data) [7];
                        // Step pointer, 4-bit wrap F to 0
                        ptr_r <= ptr_r + 1'b1;
                        state_r <= ST_TX;
                     end else begin
                        oe_r <= 1'b0;
                        state_r <= (state_r == ST_AACK) ? ST_PTR : ST_WDAT;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     bit_r <= bit_r + 1'b1;
                  end else if (scl_fall) begin
                     if (bit_r == 4'h8) begin
                        oe_r <= 1'b0;
                        state_r <= ST_MACK;
                     end else begin
                        sh_r <= {sh_r[6:0], 1'b1};
                        oe_r <= !sh_r[6];
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     rd_r <= !sda_f;
                  end else if (scl_fall) begin
                     bit_r <= 4'h0;
                     // Host NACK ends sending, wait for stop
                     if (rd_r) begin
                        sh_r <= tx_byte(dead_r, reg_rd_data);
                        oe_r <= !tx_byte(dead_r, reg_rd_data) [7];
                        ptr_r <= ptr_r + 1'b1;
                        state_r <= ST_TX;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Carry held while frozen, released the cycle after hold drops
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pend_r <= 1'b0;
         cout_r <= 1'b0;
      end else if (ce) begin
         // A carry landing in the release cycle still goes out
         pend_r <= (carry_in | pend_r) & hold_r;
         cout_r <= (carry_in | pend_r) & !hold_r;
      end
   end

   // Write queue: decouples bus bytes from the register file
   rtci_fifo #(
      .WIDTH(12),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_wq (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .ce(ce),
      .in_valid(state_r == ST_WDAT && scl_fall && bit_r == 4'h8 && !start_ev && !stop_ev
                && !timeout),
      .in_ready(fifo_in_ready),
      .in_data({ptr_r, sh_r}),
      .out_valid(reg_wr_valid),
      .out_ready(reg_wr_ready),
      .out_data({reg_wr_addr, reg_wr_data})
   );
endmodule // rtci_target

`default_nettype wire

// File: dv/rtci_target_checker.sv
/* Concurrent checks on the serial target's ports.
   Assumes it is bound onto rtci_target with its timeout parameter. */
`timescale 1ns/1ns
`default_nettype none
`include "rtci_defs.vh"
module rtci_target_checker #(
   parameter [`RTCI_TO_W-1:0] TO_TICKS = `RTCI_TO_TICKS
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_oe,
   input wire logic tick_32k,
   input wire logic carry_in,
   input wire logic carry_out,
   input wire logic time_hold,
   input wire logic [3:0] reg_rd_addr,
   input wire logic reg_wr_valid,
   input wire logic reg_wr_ready,
   input wire logic [3:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [15:0] tc_r; // Ticks seen while time is held
   logic pend_r; // A carry is waiting for release
   // Tick count and deferred carry tracking
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tc_r <= 16'h0;
         pend_r <= 1'b0;
      end else begin
         tc_r <= !time_hold ? 16'h0 : tc_r + {15'h0, tick_32k};
         pend_r <= (pend_r | (carry_in & time_hold)) & !carry_out;
      end
   end
   reset_idle_a: assert property ($rose(resetn) |-> reg_rd_addr == 4'hf && !time_hold)
      else $error("pointer or hold wrong after reset");
   carry_defer_a: assert property (time_hold && $past(time_hold) |-> !carry_out)
      else $error("carry applied during hold");
   carry_free_a: assert property (carry_in && !time_hold |=> carry_out)
      else $error("carry without hold not passed on");
   carry_late_a: assert property ($fell(time_hold) && pend_r |-> ##[0:2] carry_out)
      else $error("held carry not applied");
   stop_release_a: assert property (scl_i && $rose(sda_i) |-> ##[1:8] (reg_rd_addr == 4'hf && !time_hold))
      else $error("stop left pointer or hold");
   oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_i)
      else $error("data line pulled while clock high");
   oe_steady_a: assert property (scl_i && $past(scl_i, 6) |-> $stable(sda_oe))
      else $error("data line changed while clock high");
   timeout_fire_a: assert property (tc_r == TO_TICKS |-> ##[0:2] (!time_hold && !sda_oe && reg_rd_addr == 4'hf))
      else $error("timeout did not release");
   timeout_bound_a: assert property (time_hold |-> tc_r <= TO_TICKS)
      else $error("hold outlived timeout");
   fifo_hold_a: assert property (reg_wr_valid && !reg_wr_ready |=> reg_wr_valid && $stable({reg_wr_addr, reg_wr_data}))
      else $error("fifo output changed while stalled");
   cover property (tc_r == TO_TICKS);
   cover property ($fell(time_hold) && pend_r);
   cover property (reg_wr_valid && !reg_wr_ready);
endmodule // rtci_target_checker
bind rtci_target rtci_target_checker #(.TO_TICKS(TO_TICKS)) rtci_target_checker_inst (
   .sys_clk(sys_clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_oe(sda_oe),
   .tick_32k(tick_32k), .carry_in(carry_in), .carry_out(carry_out), .time_hold(time_hold),
   .reg_rd_addr(reg_rd_addr), .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
   .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
`default_nettype wire

// File: dv/rtci_host.sv
/* Bus controller model driving the two-wire link in timed steps.
   Assumes SDA is open drain with a pull-up resolved outside. */
`timescale 1ns/1ns
`default_nettype none
module rtci_host #(
   parameter int HALF = 64
) (
   output logic scl,
   output logic pull,
   input wire logic sda
);
   // Idle bus, both lines released
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // Data set mid-low, sampled mid-high; slow enough for the target's filter
   task automatic bit_io(input logic b, output logic r);
      #(HALF / 2) pull = !b;
      #(HALF / 2) scl = 1'b1;
      #(HALF / 2) r = sda;
      #(HALF / 2) scl = 1'b0;
   endtask
   task automatic start();
      #(HALF / 2) pull = 1'b0;
      #(HALF / 2) scl = 1'b1;
      #HALF pull = 1'b1;
      #HALF scl = 1'b0;
   endtask
   task automatic stop();
      #(HALF / 2) pull = 1'b1;
      #(HALF / 2) scl = 1'b1;
      #HALF pull = 1'b0;
      #61000;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule // rtci_host
`default_nettype wire

// File: dv/test_rtci_target.sv
/* Self-checking bench for the serial clock-chip target.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "rtci_defs.vh"
module test_rtci_target;
   localparam int TICK_CYC = 320; // Shortened timebase period
   localparam logic [7:0] WADDR = {`RTCI_TARGET_ADDR, 1'b0};
   localparam logic [7:0] RADDR = {`RTCI_TARGET_ADDR, 1'b1};
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic tick = 1'b0;
   logic carry_in = 1'b0;
   logic wr_ready = 1'b0;
   logic scl, pull, sda_o, sda_oe, carry_out, time_hold, wr_valid;
   logic [3:0] rd_addr, wr_addr;
   logic [7:0] wr_data;
   wire logic sda_w = !(pull | (sda_oe & !sda_o));
   wire logic [7:0] rd_data = {~rd_addr, rd_addr};
   int n_fail = 0, n_checks = 0, n_carry = 0, tcnt = 0;
   // Rows: form (0 pointer+Sr, 1 short, 2 bare), pointer, bytes, expected first address
   logic [15:0] rows [4] = '{16'h0232, 16'h1e4e, 16'h205f, 16'h0f2f};
   always #4 sys_clk = !sys_clk;
   // Timebase pulse on the falling edge
   always @(negedge sys_clk) begin
      tcnt = (tcnt + 1) % TICK_CYC;
      tick = (tcnt == 0);
   end
   always @(posedge sys_clk) if (carry_out === 1'b1) n_carry++;
   rtci_target #(.TO_TICKS(15'd20)) rtci_target_inst (
      .sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe), .tick_32k(tick), .carry_in(carry_in),
      .carry_out(carry_out), .time_hold(time_hold), .reg_rd_addr(rd_addr),
      .reg_rd_data(rd_data), .reg_wr_valid(wr_valid), .reg_wr_ready(wr_ready),
      .reg_wr_addr(wr_addr), .reg_wr_data(wr_data));
   rtci_host rtci_host_inst (.scl(scl), .pull(pull), .sda(sda_w));
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      if (n_fail == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic pulse();
      @(negedge sys_clk) carry_in = 1'b1;
      @(negedge sys_clk) carry_in = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic do_read(input logic [3:0] form, ptr, n, first);
      logic ack;
      logic [7:0] d;
      logic [3:0] a;
      a = first;
      rtci_host_inst.start();
      if (form != 4'h2) begin
         rtci_host_inst.wbyte(WADDR, ack);
         rtci_host_inst.wbyte({ptr, form == 4'h1 ? `RTCI_FMT_SHORT : `RTCI_FMT_NORMAL}, ack);
         chk("pointer ack", 12'h1, ack);
         if (form == 4'h0) rtci_host_inst.start();
      end
      if (form != 4'h1) rtci_host_inst.wbyte(RADDR, ack);
      chk("read ack", 12'h1, ack);
      for (int k = 0; k < n; k++) begin
         rtci_host_inst.rbyte(k == n - 1, d);
         chk("read data", {4'h0, ~a, a}, d);
         a = a + 4'h1;
      end
      rtci_host_inst.stop();
      chk("pointer after stop", 12'hf, rd_addr);
   endtask
   initial begin
      logic ack;
      logic [7:0] d;
      time t0;
      longint el;
      repeat (4) @(negedge sys_clk);
      chk("reset pointer", 12'hf, rd_addr);
      chk("reset outputs", 12'h0, {sda_o, sda_oe, time_hold, carry_out, wr_valid});
      resetn = 1'b1;
      repeat (8) @(negedge sys_clk);
      foreach (rows[i]) do_read(rows[i][15:12], rows[i][11:8], rows[i][7:4], rows[i][3:0]);
      rtci_host_inst.start();
      rtci_host_inst.wbyte(8'h66, ack);
      chk("foreign ack", 12'h0, ack);
      rtci_host_inst.stop();
      pulse();
      chk("free carry", 12'h1, n_carry);
      rtci_host_inst.start();
      rtci_host_inst.wbyte(WADDR, ack);
      chk("hold", 12'h1, time_hold);
      pulse();
      repeat (20) @(negedge sys_clk);
      chk("deferred carry", 12'h1, n_carry);
      rtci_host_inst.stop();
      chk("carry after stop", 12'h2, n_carry);
      // Fill the buffer with its reader stalled
      rtci_host_inst.start();
      rtci_host_inst.wbyte(WADDR, ack);
      rtci_host_inst.wbyte(8'h30, ack);
      for (int i = 0; i < 33; i++) begin
         rtci_host_inst.wbyte(8'h40 + i[7:0], ack);
         chk("write ack", {11'h0, i < 32}, ack);
      end
      rtci_host_inst.stop();
      for (int i = 0; i < 32; i++) begin
         @(negedge sys_clk);
         chk("fifo valid", 12'h1, wr_valid);
         chk("fifo addr", {8'h0, 4'h3 + i[3:0]}, wr_addr);
         chk("fifo data", {4'h0, 8'h40 + i[7:0]}, wr_data);
         wr_ready = 1'b1;
         @(negedge sys_clk) wr_ready = 1'b0;
      end
      @(negedge sys_clk);
      chk("fifo empty", 12'h0, wr_valid);
      // Clock stuck low after a repeated start
      rtci_host_inst.start();
      t0 = $time;
      rtci_host_inst.wbyte(WADDR, ack);
      rtci_host_inst.wbyte(8'h20, ack);
      rtci_host_inst.start();
      for (int i = 0; i < 8000 && time_hold !== 1'b0; i++) @(negedge sys_clk);
      if (time_hold !== 1'b0) begin
         n_fail++;
         conclude();
      end
      el = ($time - t0) / 8;
      chk("timeout cycles", 12'h1, el >= 19 * TICK_CYC - 16 && el <= 20 * TICK_CYC + 4);
      chk("timeout pointer", 12'hf, rd_addr);
      rtci_host_inst.start();
      rtci_host_inst.wbyte(RADDR, ack);
      chk("dead read ack", 12'h1, ack);
      rtci_host_inst.rbyte(1'b1, d);
      chk("dead read data", 12'hff, d);
      rtci_host_inst.start();
      rtci_host_inst.wbyte(WADDR, ack);
      chk("dead write ack", 12'h0, ack);
      rtci_host_inst.stop();
      conclude();
   end
endmodule // test_rtci_target
`default_nettype wire
